// ---- logic/timetag_defines.svh ----
// Offsets, field positions, reset values and timing counts for the time tag
// and interrupt block. Included by the package and the design file.
`ifndef TIMETAG_DEFINES_SVH
`define TIMETAG_DEFINES_SVH
`define ADDR_INT_MASK 5'h00
`define ADDR_CFG1 5'h01
`define ADDR_CFG2 5'h02
`define ADDR_START_RESET 5'h03
`define ADDR_TIME_TAG 5'h05
`define ADDR_INT_STATUS 5'h06
`define ADDR_CFG3 5'h07
`define ADDR_CFG4 5'h08
// Configuration 1 fields
`define CFG1_SLOW_CLK 0
`define CFG1_SVC_REQ 1
// Configuration 2 fields
`define CFG2_RES_LSB 0
`define CFG2_EXT_TAG 3
`define CFG2_SYNC_CLR_EN 4
`define CFG2_SYNC_LOAD_EN 5
`define CFG2_ROLL_EN 6
`define CFG2_AUTO_SVC_CLR 7
`define CFG2_INT_MODE_LSB 8
`define CFG2_ENHANCED 10
// Configuration 3 fields
`define CFG3_TIMEOUT_LSB 0
// Start/reset command bits
`define SR_SOFT_RESET 0
`define SR_INT_RESET 1
`define SR_TAG_RESET 2
`define SR_TAG_TEST 3
// Status layout
`define STAT_ROLLOVER 14
`define STAT_MASTER 15
// Reset values and time tag maximum
`define CFG_RESET 16'h0000
`define MASK_RESET 15'h0000
`define GAP_RESET 16'h0000
`define TAG_RESET_VAL 16'h0000
`define TAG_MAX 16'hFFFF
// Timing
`define CLK_PERIOD_NS 20
`define US_NS 1000
`define CYC_PER_US (`US_NS / `CLK_PERIOD_NS)
`endif

// ---- logic/timetag_pkg.sv ----
// Types for the time tag and interrupt block.
// Assumes the constants header sits beside it.
`include "timetag_defines.svh"
package timetag_pkg;
   typedef enum logic [1:0] {
      INT_PULSE = 2'b00,
      INT_LEVEL_SW = 2'b01,
      INT_LEVEL_AUTO = 2'b11
   } int_mode_t;

   typedef struct packed {
      logic cs;
      logic rd;
      logic wr;
      logic [4:0] addr;
      logic [15:0] wdata;
   } host_req_t;

   typedef struct packed {
      logic nodata;
      logic withdata;
      logic [15:0] data;
   } sync_cmd_t;
endpackage : timetag_pkg

// ---- logic/timetag_int_core.sv ----
// Time tag counter, interrupt status/mask logic and timing configuration.
// Assumes host strobes and protocol events arrive on ref_clk_in.
//Contract
//- After any reset decoders sample on the full system clock.
//- Slow clock option makes decoders sample on both edges.
//- Host read/write 16-bit time tag, tick 2 to 64 us selectable.
//- Time tag may advance on an external oscillator input instead.
//- Software command can step the time tag for self-test.
//- Each message copies the time tag into its descriptor second word.
//- Synchronize without data clears the time tag when enabled.
//- Synchronize with data loads the time tag when enabled.
//- Time tag wrap sets rollover status and requests interrupt when enabled.
//- Option clears service request bit after transmit vector word answer.
//- Interrupt output: pulse, level cleared by software, or read-cleared level.
//- A condition drives interrupt only when its mask bit is set.
//- Standard mode updates status bit only if condition and mask.
//- Enhanced mode updates status bit whenever condition occurs.
//- Controller gap lengthened in 1 us steps by software.
//- Four selectable no-response timeouts, also for terminal-to-terminal.
//- Status register shows all conditions in one read.
`timescale 1ns/100ps
`include "timetag_defines.svh"
module timetag_int_core
   import timetag_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // Host register port
   input wire host_req_t host_req_in,
   output logic [15:0] host_rdata_out,
   // Protocol events
   input wire logic [13:0] int_events_in,
   input wire sync_cmd_t sync_cmd_in,
   input wire logic msg_done_in,
   input wire logic vector_answered_in,
   input wire logic ext_tag_clk_in,
   // Outputs to protocol logic
   output logic sample_both_edges_out,
   output logic [15:0] stack_tag_word_out,
   output logic stack_tag_wr_out,
   output logic svc_req_out,
   output logic [15:0] bc_gap_us_out,
   output logic [1:0] timeout_sel_out,
   output logic int_out
);
   logic [15:0] cfg1_r, cfg2_r, cfg3_r;
   logic [14:0] mask_r, status_r, status_nxt;
   logic [15:0] tag_r;
   logic soft_rst_r;
   logic [5:0] us_cnt_r, res_cnt_r;
   logic ext_s1_r, ext_s2_r, ext_s3_r;
   logic us_tick, res_tick, tag_inc, tag_load, rollover_ev;
   logic wr_cmd, rd_status;
   logic [14:0] ev;
   int_mode_t int_mode;

   function automatic logic [5:0] res_last(input logic [2:0] sel);
      logic [5:0] us;
      us = 6'h02 << sel;
      res_last = us - 6'h01;
   endfunction : res_last

   function automatic logic hit(input host_req_t q, input logic [4:0] a);
      hit = q.cs && q.addr == a;
   endfunction : hit

   assign wr_cmd = host_req_in.wr && hit(host_req_in, `ADDR_START_RESET);
   assign rd_status = host_req_in.rd && hit(host_req_in, `ADDR_INT_STATUS);
   assign int_mode = int_mode_t'(cfg2_r[`CFG2_INT_MODE_LSB +: 2]);

   // Soft reset takes effect one cycle after the command write
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= wr_cmd && host_req_in.wdata[`SR_SOFT_RESET];
      end
   end

   // Configuration registers
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cfg1_r <= `CFG_RESET;
         cfg2_r <= `CFG_RESET;
         cfg3_r <= `CFG_RESET;
         mask_r <= `MASK_RESET;
         bc_gap_us_out <= `GAP_RESET;
      end else if (soft_rst_r) begin
         cfg1_r <= `CFG_RESET;
         cfg2_r <= `CFG_RESET;
         cfg3_r <= `CFG_RESET;
         mask_r <= `MASK_RESET;
         bc_gap_us_out <= `GAP_RESET;
      end else if (host_req_in.wr && host_req_in.cs) begin
         if (host_req_in.addr == `ADDR_CFG1) begin
            cfg1_r <= host_req_in.wdata;
         end else if (host_req_in.addr == `ADDR_CFG2) begin
            cfg2_r <= host_req_in.wdata;
         end else if (host_req_in.addr == `ADDR_CFG3) begin
            cfg3_r <= host_req_in.wdata;
         end else if (host_req_in.addr == `ADDR_INT_MASK) begin
            mask_r <= host_req_in.wdata[14:0];
         end else if (host_req_in.addr == `ADDR_CFG4) begin
            bc_gap_us_out <= host_req_in.wdata;
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sample_both_edges_out <= 1'b0;
         timeout_sel_out <= 2'b00;
      end else begin
         sample_both_edges_out <= cfg1_r[`CFG1_SLOW_CLK];
         timeout_sel_out <= cfg3_r[`CFG3_TIMEOUT_LSB +: 2];
      end
   end

   // External oscillator synchroniser; third stage only for edge detect
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
      end else begin
         ext_s1_r <= ext_tag_clk_in;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end

   // Microsecond prescaler and resolution divider
   assign us_tick = us_cnt_r == 6'(`CYC_PER_US - 1);
   assign res_tick = us_tick && res_cnt_r >= res_last(cfg2_r[`CFG2_RES_LSB +: 3]);
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         us_cnt_r <= 6'h00;
         res_cnt_r <= 6'h00;
      end else begin
         us_cnt_r <= us_tick ? 6'h00 : us_cnt_r + 6'h01;
         if (res_tick) begin
            res_cnt_r <= 6'h00;
         end else if (us_tick) begin
            res_cnt_r <= res_cnt_r + 6'h01;
         end
      end
   end

   assign tag_inc = (cfg2_r[`CFG2_EXT_TAG] ? (ext_s2_r && !ext_s3_r) : res_tick)
      || (wr_cmd && host_req_in.wdata[`SR_TAG_TEST]);
   assign tag_load = (host_req_in.wr && hit(host_req_in, `ADDR_TIME_TAG))
      || (sync_cmd_in.withdata && cfg2_r[`CFG2_SYNC_LOAD_EN])
      || (sync_cmd_in.nodata && cfg2_r[`CFG2_SYNC_CLR_EN])
      || (wr_cmd && host_req_in.wdata[`SR_TAG_RESET]);
   assign rollover_ev = cfg2_r[`CFG2_ROLL_EN] && tag_inc && !tag_load
      && tag_r == `TAG_MAX;

   // Time tag counter; host write beats sync load beats clear
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         tag_r <= `TAG_RESET_VAL;
      end else if (host_req_in.wr && hit(host_req_in, `ADDR_TIME_TAG)) begin
         tag_r <= host_req_in.wdata;
      end else if (sync_cmd_in.withdata && cfg2_r[`CFG2_SYNC_LOAD_EN]) begin
         tag_r <= sync_cmd_in.data;
      end else if (tag_load) begin
         tag_r <= `TAG_RESET_VAL;
      end else if (tag_inc) begin
         tag_r <= tag_r + 16'h0001;
      end
   end

   // Descriptor stack time tag word
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         stack_tag_word_out <= 16'h0000;
         stack_tag_wr_out <= 1'b0;
      end else begin
         stack_tag_wr_out <= msg_done_in;
         if (msg_done_in) begin
            stack_tag_word_out <= tag_r;
         end
      end
   end

   // Service request: host write sets or clears, answered vector clears when CFG2_AUTO_SVC_CLR is set
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         svc_req_out <= 1'b0;
      end else if (host_req_in.wr && hit(host_req_in, `ADDR_CFG1)) begin
         svc_req_out <= host_req_in.wdata[`CFG1_SVC_REQ];
      end else if (vector_answered_in && cfg2_r[`CFG2_AUTO_SVC_CLR]) begin
         svc_req_out <= 1'b0;
      end
   end

   // Interrupt status; a new event in the clearing cycle survives
   assign ev = {rollover_ev, int_events_in};
   always_comb begin
      status_nxt = status_r;
      if ((wr_cmd && host_req_in.wdata[`SR_INT_RESET])
            || (rd_status && int_mode == INT_LEVEL_AUTO)) begin
         status_nxt = 15'h0000;
      end
      if (cfg2_r[`CFG2_ENHANCED]) begin
         status_nxt = status_nxt | ev;
      end else begin
         status_nxt = status_nxt | (ev & mask_r);
      end
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         status_r <= 15'h0000;
      end else if (soft_rst_r) begin
         status_r <= 15'h0000;
      end else begin
         status_r <= status_nxt;
      end
   end

   // Interrupt pin
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         int_out <= 1'b0;
      end else if (int_mode == INT_PULSE) begin
         int_out <= |(ev & mask_r);
      end else begin
         int_out <= |(status_nxt & mask_r);
      end
   end

   // Read data, registered one cycle after the strobe
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         host_rdata_out <= 16'h0000;
      end else if (host_req_in.rd && host_req_in.cs) begin
         if (host_req_in.addr == `ADDR_INT_MASK) begin
            host_rdata_out <= {1'b0, mask_r};
         end else if (host_req_in.addr == `ADDR_CFG1) begin
            host_rdata_out <= {cfg1_r[15:2], svc_req_out, cfg1_r[0]};
         end else if (host_req_in.addr == `ADDR_CFG2) begin
            host_rdata_out <= cfg2_r;
         end else if (host_req_in.addr == `ADDR_TIME_TAG) begin
            host_rdata_out <= tag_r;
         end else if (host_req_in.addr == `ADDR_INT_STATUS) begin
            host_rdata_out <= {|(status_r & mask_r), status_r};
         end else if (host_req_in.addr == `ADDR_CFG3) begin
            host_rdata_out <= cfg3_r;
         end else if (host_req_in.addr == `ADDR_CFG4) begin
            host_rdata_out <= bc_gap_us_out;
         end else begin
            host_rdata_out <= 16'h0000;
         end
      end
   end

   property p_default_fast;
      @(posedge ref_clk_in) $fell(sys_rst_in) |-> !sample_both_edges_out;
   endproperty
   a_default_fast: assert property (p_default_fast) else $error("slow mode after reset");

   property p_slow;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
         cfg1_r[`CFG1_SLOW_CLK] |=> sample_both_edges_out;
   endproperty
   a_slow: assert property (p_slow) else $error("slow clock not followed");

   property p_tick;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
         (res_tick && !cfg2_r[`CFG2_EXT_TAG] && !tag_load) |=> tag_r == $past(tag_r) + 16'h0001;
   endproperty
   a_tick: assert property (p_tick) else $error("tag missed tick");

   property p_step;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
         (wr_cmd && host_req_in.wdata[`SR_TAG_TEST] && !tag_load)
            |=> tag_r == $past(tag_r) + 16'h0001;
   endproperty
   a_step: assert property (p_step) else $error("test step lost");

   property p_stack;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
         msg_done_in |=> stack_tag_wr_out && stack_tag_word_out == $past(tag_r);
   endproperty
   a_stack: assert property (p_stack) else $error("stack tag wrong");

   property p_sync_clr;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
         (sync_cmd_in.nodata && cfg2_r[`CFG2_SYNC_CLR_EN] && !host_req_in.wr
            && !sync_cmd_in.withdata) |=> tag_r == 16'h0000;
   endproperty
   a_sync_clr: assert property (p_sync_clr) else $error("sync clear missed");

   property p_roll;
      @(posedge ref_clk_in) disable iff (sys_rst_in || soft_rst_r) rollover_ev
         && (cfg2_r[`CFG2_ENHANCED] || mask_r[`STAT_ROLLOVER]) |=> status_r[`STAT_ROLLOVER];
   endproperty
   a_roll: assert property (p_roll) else $error("rollover flag missing");

   property p_svc;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
         (vector_answered_in && cfg2_r[`CFG2_AUTO_SVC_CLR] && !(host_req_in.wr
            && hit(host_req_in, `ADDR_CFG1))) |=> !svc_req_out;
   endproperty
   a_svc: assert property (p_svc) else $error("service request kept");

   property p_masked;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
         (int_mode != INT_PULSE && (status_nxt & mask_r) == 15'h0000) |=> !int_out;
   endproperty
   a_masked: assert property (p_masked) else $error("unmasked interrupt");

   property p_std;
      @(posedge ref_clk_in) disable iff (sys_rst_in || soft_rst_r)
         (!cfg2_r[`CFG2_ENHANCED] && !status_r[0] && !mask_r[0]) |=> !status_r[0];
   endproperty
   a_std: assert property (p_std) else $error("masked bit set");

   property p_enh;
      @(posedge ref_clk_in) disable iff (sys_rst_in || soft_rst_r)
         (cfg2_r[`CFG2_ENHANCED] && int_events_in[0]) |=> status_r[0];
   endproperty
   a_enh: assert property (p_enh) else $error("enhanced bit lost");

   property p_pulse;
      @(posedge ref_clk_in) disable iff (sys_rst_in)
         (int_mode == INT_PULSE && |(ev & mask_r)) ##1 (int_mode == INT_PULSE
            && (ev & mask_r) == 15'h0000) |=> !int_out;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse too long");
endmodule : timetag_int_core

// ---- tb/host_model.sv ----
// Host processor model: one-cycle register strobes on the host port.
// Assumes the block's clock; write data is scrambled while idle.
`timescale 1ns/100ps
module host_model
   import timetag_pkg::*;
(
   // Clock
   input wire logic clk_in,
   // Register port
   output host_req_t req_out,
   input wire logic [15:0] rdata_in
);
   initial req_out = '0;

   task automatic acc(input logic rd, input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_in);
      req_out <= '{cs: 1'b1, rd: rd, wr: !rd, addr: a, wdata: d};
      @(posedge clk_in);
      req_out <= '{cs: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
      #1;
   endtask : acc

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      acc(1'b0, a, d);
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      acc(1'b1, a, 16'h0000);
      d = rdata_in;
   endtask : rd
endmodule : host_model

// ---- tb/bus_terminal_timetag_interrupt_bench.sv ----
// Self-checking bench for the time tag and interrupt core.
// Assumes the host model owns the register port; events are driven here.
`timescale 1ns/100ps
module bus_terminal_timetag_interrupt_bench
   import timetag_pkg::*;
;
   localparam int LIMIT = 20000;
   logic ref_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   host_req_t host_req;
   logic [15:0] host_rdata, stack_word, gap, r, v;
   logic [13:0] int_events = '0;
   sync_cmd_t sync_cmd = '0;
   logic msg_done = 1'b0;
   logic vec_ans = 1'b0;
   logic ext_clk = 1'b0;
   logic sample_both, stack_wr, svc_req, int_o;
   logic [1:0] tmo;
   logic [13:0] m, e;
   logic [31:0] rnd;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   integer seed = 32'h2d95_0172;

   initial forever #10 ref_clk_in = ~ref_clk_in;

   timetag_int_core u_timetag_int_core (
      .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .host_req_in(host_req), .host_rdata_out(host_rdata),
      .int_events_in(int_events), .sync_cmd_in(sync_cmd),
      .msg_done_in(msg_done), .vector_answered_in(vec_ans),
      .ext_tag_clk_in(ext_clk), .sample_both_edges_out(sample_both),
      .stack_tag_word_out(stack_word), .stack_tag_wr_out(stack_wr),
      .svc_req_out(svc_req), .bc_gap_us_out(gap),
      .timeout_sel_out(tmo), .int_out(int_o)
   );

   host_model u_host_model (.clk_in(ref_clk_in), .req_out(host_req), .rdata_in(host_rdata));

   function automatic logic exp_int(input logic [13:0] mk, input logic [13:0] ev);
      return |(mk & ev);
   endfunction : exp_int

   task automatic final_report;
      $display("Comparisons %0d, errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] d;
      u_host_model.rd(a, d);
      chk(d, exp);
   endtask : rchk

   // k = {sync with data, sync without data, message done, vector answered}
   task automatic fire(input logic [13:0] ev, input logic [3:0] k, input logic [15:0] d);
      @(posedge ref_clk_in);
      int_events <= ev;
      sync_cmd <= '{nodata: k[2], withdata: k[3], data: d};
      msg_done <= k[1];
      vec_ans <= k[0];
      @(posedge ref_clk_in);
      int_events <= '0;
      sync_cmd <= '{nodata: 1'b0, withdata: 1'b0, data: ~d};
      msg_done <= 1'b0;
      vec_ans <= 1'b0;
      #1;
   endtask : fire

   // Held well past the two-cycle synchroniser latency
   task automatic ext_edge;
      @(posedge ref_clk_in);
      ext_clk <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      ext_clk <= 1'b0;
      repeat (5) @(posedge ref_clk_in);
      #1;
   endtask : ext_edge

   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         num_errors++;
         $display("Error at %0t: timeout", $time);
         final_report();
      end
   end

   initial begin
      repeat (10) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      @(posedge ref_clk_in);
      #1;
      chk({12'h000, sample_both, svc_req, int_o, stack_wr}, 16'h0000);
      // Free-running prescaler: phase unknown, so two or three ticks
      u_host_model.wr(5'h02, 16'h0001);
      u_host_model.wr(5'h05, 16'h0000);
      repeat (400) @(posedge ref_clk_in);
      u_host_model.rd(5'h05, r);
      chk({15'h0000, (r === 16'h0002) || (r === 16'h0003)}, 16'h0001);
      // External clock mode stops the internal tick from advancing the tag
      u_host_model.wr(5'h02, 16'h0038);
      rnd = $random(seed);
      v = rnd[15:0];
      u_host_model.wr(5'h05, v);
      rchk(5'h05, v);
      u_host_model.wr(5'h03, 16'h0008);
      rchk(5'h05, v + 16'h0001);
      ext_edge();
      rchk(5'h05, v + 16'h0002);
      fire(14'h0000, 4'b0010, 16'h0000);
      chk({15'h0000, stack_wr}, 16'h0001);
      chk(stack_word, v + 16'h0002);
      fire(14'h0000, 4'b0100, 16'h0000);
      rchk(5'h05, 16'h0000);
      fire(14'h0000, 4'b1000, ~v);
      rchk(5'h05, ~v);
      u_host_model.wr(5'h00, 16'h4000);
      u_host_model.wr(5'h02, 16'h0148);
      u_host_model.wr(5'h05, 16'hffff);
      ext_edge();
      chk({15'h0000, int_o}, 16'h0001);
      rchk(5'h06, 16'hc000);
      rchk(5'h05, 16'h0000);
      u_host_model.wr(5'h03, 16'h0002);
      chk({15'h0000, int_o}, 16'h0000);
      u_host_model.wr(5'h01, 16'h0002);
      chk({15'h0000, svc_req}, 16'h0001);
      u_host_model.wr(5'h02, 16'h0088);
      fire(14'h0000, 4'b0001, 16'h0000);
      chk({15'h0000, svc_req}, 16'h0000);
      u_host_model.wr(5'h02, 16'h0008);
      for (int i = 0; i < 12; i++) begin
         rnd = $random(seed);
         m = (i == 0) ? 14'h0000 : rnd[13:0];
         e = (i == 1) ? 14'h3fff : rnd[29:16];
         u_host_model.wr(5'h00, {2'b00, m});
         fire(e, 4'b0000, 16'h0000);
         chk({15'h0000, int_o}, {15'h0000, exp_int(m, e)});
         @(posedge ref_clk_in);
         #1;
         chk({15'h0000, int_o}, 16'h0000);
      end
      u_host_model.wr(5'h03, 16'h0002);
      u_host_model.wr(5'h00, 16'h0001);
      fire(14'h0006, 4'b0000, 16'h0000);
      rchk(5'h06, 16'h0000);
      u_host_model.wr(5'h02, 16'h0408);
      fire(14'h0006, 4'b0000, 16'h0000);
      chk({15'h0000, int_o}, 16'h0000);
      rchk(5'h06, 16'h0006);
      fire(14'h0001, 4'b0000, 16'h0000);
      rchk(5'h06, 16'h8007);
      u_host_model.wr(5'h03, 16'h0002);
      u_host_model.wr(5'h02, 16'h0308);
      fire(14'h0001, 4'b0000, 16'h0000);
      chk({15'h0000, int_o}, 16'h0001);
      rchk(5'h06, 16'h8001);
      chk({15'h0000, int_o}, 16'h0000);
      rchk(5'h06, 16'h0000);
      for (int t = 0; t < 4; t++) begin
         u_host_model.wr(5'h07, 16'(t));
         @(posedge ref_clk_in);
         #1;
         chk({14'h0000, tmo}, 16'(t));
      end
      rnd = $random(seed);
      u_host_model.wr(5'h08, rnd[15:0]);
      chk(gap, rnd[15:0]);
      rchk(5'h08, rnd[15:0]);
      rchk(5'h1f, 16'h0000);
      u_host_model.wr(5'h01, 16'h0001);
      @(posedge ref_clk_in);
      #1;
      chk({15'h0000, sample_both}, 16'h0001);
      u_host_model.wr(5'h03, 16'h0001);
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk({15'h0000, sample_both}, 16'h0000);
      rchk(5'h01, 16'h0000);
      final_report();
   end
endmodule : bus_terminal_timetag_interrupt_bench
